// *** occ_conversion_control.sv ***
`timescale 1ns/1ps
`include "occ_params.svh"
// Overview of operation
// - command 01h is one byte, written by write-byte, returned by read-byte.
// - bit 7 resets zero; with command control, 0 disables and 1 enables conversion.
// - enable request set also arms ignore-faults for the chosen margin.
// - conversion starts only when all other start conditions also hold.
// - bit 6 picks turn-off profile, used only on a one-to-zero enable fall.
// - profile zero stops conversion at once and tri-states the power stage.
// - profile one holds for hold time, ramps to 0 V, then stops.
// - margin bits 5:2 reset zero; 0000b, 0001b, 0010b give nominal target.
// - 0101b targets lower margin; faults ignored while enable request is one.
// - 0110b targets lower margin; faults act normally.
// - 1001b targets upper margin; faults ignored while enable request is one.
// - 1010b targets upper margin; faults act normally.
// - bits 1 and 0 always read zero.
// - invalid write values are not stored and flag status on invalid_data_out.
// - enable request starts or stops conversion only when the command-source config bit is one; ignore-faults arming does not depend on it.
module occ_conversion_control (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] wr_data_in,
  input wire logic cmd_source_en_in,
  input wire logic start_ok_in,
  input wire logic [`OCC_CNT_W-1:0] turnoff_hold_time_in,
  input wire logic vout_at_zero_in,
  output logic [7:0] rd_data_out,
  output logic invalid_data_out,
  output logic converting_out,
  output logic stage_hiz_out,
  output logic ramp_down_out,
  output logic [1:0] target_sel_out,
  output logic ignore_faults_out
);
  // ------------------------------------------------------------
  // register
  // ------------------------------------------------------------
  logic [7:0] conversion_control_command;
  logic valid_value;
  logic [3:0] wr_margin;
  logic cmd_write;
  assign wr_margin = wr_data_in[`OCC_MARGIN_HI:`OCC_MARGIN_LO];
  assign cmd_write = wr_en_in && (cmd_code_in == `OCC_CMD_CODE);
  always_comb begin
    unique case (wr_margin)
      `OCC_MARGIN_OFF0, `OCC_MARGIN_OFF1, `OCC_MARGIN_OFF2,
      `OCC_MARGIN_LOW_IGN, `OCC_MARGIN_LOW_ACT,
      `OCC_MARGIN_HIGH_IGN, `OCC_MARGIN_HIGH_ACT: valid_value = 1'b1;
      default: valid_value = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      conversion_control_command <= `OCC_RESET_VALUE;
    end else if (cmd_write && valid_value) begin
      // low bits masked so they always read zero
      conversion_control_command <= wr_data_in & `OCC_LOW_BITS_MASK;
    end
  end
  // ------------------------------------------------------------
  // read and invalid flag
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_data_out <= `OCC_RESET_VALUE;
    end else if (rd_en_in && (cmd_code_in == `OCC_CMD_CODE)) begin
      rd_data_out <= conversion_control_command;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      invalid_data_out <= 1'b0;
    end else begin
      invalid_data_out <= cmd_write && !valid_value;
    end
  end
  // ------------------------------------------------------------
  // margin decode
  // ------------------------------------------------------------
  logic [3:0] margin;
  logic on_req;
  assign margin = conversion_control_command[`OCC_MARGIN_HI:`OCC_MARGIN_LO];
  assign on_req = conversion_control_command[`OCC_BIT_ON];
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      target_sel_out <= occ_pkg::OCC_TARGET_NOMINAL;
      ignore_faults_out <= 1'b0;
    end else begin
      unique case (margin)
        `OCC_MARGIN_LOW_IGN: begin
          target_sel_out <= occ_pkg::OCC_TARGET_LOWER;
          ignore_faults_out <= on_req;
        end
        `OCC_MARGIN_LOW_ACT: begin
          target_sel_out <= occ_pkg::OCC_TARGET_LOWER;
          ignore_faults_out <= 1'b0;
        end
        `OCC_MARGIN_HIGH_IGN: begin
          target_sel_out <= occ_pkg::OCC_TARGET_UPPER;
          ignore_faults_out <= on_req;
        end
        `OCC_MARGIN_HIGH_ACT: begin
          target_sel_out <= occ_pkg::OCC_TARGET_UPPER;
          ignore_faults_out <= 1'b0;
        end
        default: begin
          target_sel_out <= occ_pkg::OCC_TARGET_NOMINAL;
          ignore_faults_out <= 1'b0;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // turn-on / turn-off sequencer
  // ------------------------------------------------------------
  occ_pkg::occ_state_t state;
  logic [`OCC_CNT_W-1:0] hold_cnt;
  logic on_req_d;
  logic fall;
  assign fall = on_req_d && !on_req && cmd_source_en_in;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      on_req_d <= 1'b0;
    end else begin
      on_req_d <= on_req;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= occ_pkg::OCC_ST_OFF;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        occ_pkg::OCC_ST_OFF: begin
          if (cmd_source_en_in && on_req && start_ok_in) begin
            state <= occ_pkg::OCC_ST_ON;
          end
        end
        occ_pkg::OCC_ST_ON: begin
          if (fall) begin
            if (conversion_control_command[`OCC_BIT_SOFT]) begin
              state <= occ_pkg::OCC_ST_HOLD;
              hold_cnt <= turnoff_hold_time_in;
            end else begin
              state <= occ_pkg::OCC_ST_OFF;
            end
          end
        end
        occ_pkg::OCC_ST_HOLD: begin
          if (hold_cnt == '0) begin
            state <= occ_pkg::OCC_ST_RAMP;
          end else begin
            hold_cnt <= hold_cnt - 1'b1;
          end
        end
        occ_pkg::OCC_ST_RAMP: begin
          if (vout_at_zero_in) begin
            state <= occ_pkg::OCC_ST_OFF;
          end
        end
      endcase
    end
  end
  assign converting_out = (state != occ_pkg::OCC_ST_OFF);
  assign stage_hiz_out = (state == occ_pkg::OCC_ST_OFF);
  assign ramp_down_out = (state == occ_pkg::OCC_ST_RAMP);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_LOW_BITS_ZERO: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (conversion_control_command & ~`OCC_LOW_BITS_MASK) == '0) else $error("low bits not zero");
  AST_INVALID_KEEPS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cmd_write && !valid_value |=> $stable(conversion_control_command))
    else $error("invalid write changed register");
  AST_INVALID_FLAG: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cmd_write && !valid_value |=> invalid_data_out) else $error("invalid not flagged");
  AST_NO_START: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_OFF && !start_ok_in |=> state == occ_pkg::OCC_ST_OFF)
    else $error("started without conditions");
  AST_NO_CMD_SRC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_OFF && !cmd_source_en_in |=> !converting_out)
    else $error("started with command source off");
  AST_HARD_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_ON && fall && !conversion_control_command[`OCC_BIT_SOFT]
    |=> stage_hiz_out) else $error("immediate off failed");
  AST_SOFT_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_ON && fall && conversion_control_command[`OCC_BIT_SOFT]
    |=> converting_out && !ramp_down_out) else $error("soft off did not hold");
  AST_RAMP_END: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ramp_down_out && vout_at_zero_in |=> !converting_out) else $error("ramp not ended");
  AST_IGN_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    margin == `OCC_MARGIN_HIGH_IGN && on_req |=> ignore_faults_out &&
    target_sel_out == occ_pkg::OCC_TARGET_UPPER) else $error("high margin ignore wrong");
  AST_ACT_LOW: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    margin == `OCC_MARGIN_LOW_ACT |=> !ignore_faults_out &&
    target_sel_out == occ_pkg::OCC_TARGET_LOWER) else $error("low margin act wrong");
  AST_IGN_LOW: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    margin == `OCC_MARGIN_LOW_IGN && on_req |=> ignore_faults_out &&
    target_sel_out == occ_pkg::OCC_TARGET_LOWER) else $error("low margin ignore wrong");
  AST_ACT_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    margin == `OCC_MARGIN_HIGH_ACT |=> !ignore_faults_out &&
    target_sel_out == occ_pkg::OCC_TARGET_UPPER) else $error("high margin act wrong");
  AST_MARGIN_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (margin == `OCC_MARGIN_OFF0 || margin == `OCC_MARGIN_OFF1 || margin == `OCC_MARGIN_OFF2)
    |=> !ignore_faults_out && target_sel_out == occ_pkg::OCC_TARGET_NOMINAL)
    else $error("margin off decode wrong");
  AST_START: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_OFF && cmd_source_en_in && on_req && start_ok_in
    |=> converting_out) else $error("enable request did not start");
  AST_ON_KEEPS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_ON && on_req |=> state == occ_pkg::OCC_ST_ON)
    else $error("turned off while enable request set");
  AST_HOLD_STAYS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == occ_pkg::OCC_ST_HOLD && hold_cnt != '0 |=> converting_out && !ramp_down_out)
    else $error("hold time cut short");
  AST_READ_BACK: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && cmd_code_in == `OCC_CMD_CODE
    |=> rd_data_out == $past(conversion_control_command))
    else $error("read data wrong");
  AST_VALID_STORE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cmd_write && valid_value |=> conversion_control_command ==
    ($past(wr_data_in) & `OCC_LOW_BITS_MASK)) else $error("valid write not stored");
endmodule : occ_conversion_control

// *** occ_conversion_control_bench.sv ***
`timescale 1ns/1ps
// ----
// bench
// ----
module output_operation_command_bench;
  localparam logic [23:0] HOLD = 24'h000005;
  // margin codes, GOOD used from the top nibble, BAD from the bottom nibble
  localparam logic [27:0] GOOD = 28'h012569A;
  localparam logic [35:0] BAD = 36'h3478BCDEF;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic src = 1'b1;
  logic ok = 1'b0;
  logic vz = 1'b0;
  logic wr_en, rd_en, conv, hiz, ramp, ign, inv;
  logic [7:0] code, wdata, rdata, got;
  logic [1:0] tsel;
  int failures = 0;
  int checks_done = 0;
  always #10 clk_in = ~clk_in;
  occ_host_model host (.clk_in(clk_in), .rd_data_in(rdata), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .cmd_code_out(code), .wr_data_out(wdata));
  occ_conversion_control uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .cmd_code_in(code), .wr_data_in(wdata), .cmd_source_en_in(src),
    .start_ok_in(ok), .turnoff_hold_time_in(HOLD), .vout_at_zero_in(vz), .rd_data_out(rdata),
    .invalid_data_out(inv), .converting_out(conv), .stage_hiz_out(hiz), .ramp_down_out(ramp),
    .target_sel_out(tsel), .ignore_faults_out(ign));
  task automatic compare(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks_done++;
    if (got_v !== exp_v) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : compare
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] d);
    host.write_byte(8'h01, d);
  endtask : wr
  task automatic rd_check(input logic [7:0] exp_v);
    host.read_byte(8'h01, got);
    compare(got, exp_v);
  endtask : rd_check
  // converting, high-z, ramping
  task automatic state_check(input logic [2:0] exp_v);
    compare({5'h00, conv, hiz, ramp}, {5'h00, exp_v});
  endtask : state_check
  task automatic final_report;
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic test_reset;
    rd_check(8'h00);
    state_check(3'b010);
    compare({6'h00, tsel}, 8'h00);
  endtask : test_reset
  task automatic test_valid;
    logic [7:0] d;
    logic [1:0] t;
    logic [3:0] m;
    for (int on = 0; on < 2; on++) begin
      for (int i = 6; i >= 0; i--) begin
        m = GOOD[4*i +: 4];
        d = {on[0], 1'b0, m, 2'b11};
        t = (m > 4'h8) ? 2'h2 : (m > 4'h4) ? 2'h1 : 2'h0;
        wr(d);
        compare({7'h00, inv}, 8'h00);
        tick(1);
        compare({6'h00, tsel}, {6'h00, t});
        compare({7'h00, ign}, {7'h00, on[0] && (m == 4'h5 || m == 4'h9)});
        state_check(3'b010);
        rd_check({d[7:2], 2'b00});
      end
    end
  endtask : test_valid
  task automatic test_invalid;
    for (int i = 0; i < 9; i++) begin
      wr({2'b00, BAD[4*i +: 4], 2'b00});
      compare({7'h00, inv}, 8'h01);
      rd_check(8'hA8);
    end
    host.write_byte(8'h02, 8'h3C);
    compare({7'h00, inv}, 8'h00);
    rd_check(8'hA8);
  endtask : test_invalid
  task automatic test_enable;
    wr(8'h00);
    src = 1'b0;
    ok = 1'b1;
    wr(8'h80);
    tick(2);
    state_check(3'b010);
    wr(8'h00);
    src = 1'b1;
    wr(8'h80);
    tick(2);
    state_check(3'b100);
    wr(8'hC0);
    tick(2);
    state_check(3'b100);
    wr(8'h80);
    wr(8'h00);
    tick(2);
    state_check(3'b010);
  endtask : test_enable
  task automatic test_soft;
    wr(8'h80);
    tick(2);
    wr(8'h40);
    tick(2);
    state_check(3'b100);
    tick(int'(HOLD) - 1);
    state_check(3'b100);
    tick(1);
    state_check(3'b101);
    vz = 1'b1;
    tick(3);
    state_check(3'b010);
    vz = 1'b0;
    wr(8'h80);
    tick(2);
    src = 1'b0;
    wr(8'h00);
    tick(2);
    state_check(3'b100);
    src = 1'b1;
    wr(8'h80);
    wr(8'h00);
    tick(2);
    state_check(3'b010);
  endtask : test_soft
  initial begin
    tick(2);
    reset_n_in = 1'b1;
    test_reset();
    test_valid();
    test_invalid();
    test_enable();
    test_soft();
    final_report();
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule : output_operation_command_bench

// *** occ_host_model.sv ***
`timescale 1ns/1ps
// ----
// host side byte transfers
// ----
module occ_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] cmd_code_out,
  output logic [7:0] wr_data_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    cmd_code_out = 8'h00;
    wr_data_out = 8'hFF;
  end
  task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_in);
    #1;
    cmd_code_out = code;
    wr_data_out = data;
    wr_en_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    wr_data_out = ~data;
  endtask : write_byte
  task automatic read_byte(input logic [7:0] code, output logic [7:0] data);
    @(posedge clk_in);
    #1;
    cmd_code_out = code;
    rd_en_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    data = rd_data_in;
  endtask : read_byte
endmodule : occ_host_model

// *** occ_params.svh ***
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
`define OCC_CMD_CODE 8'h01
`define OCC_RESET_VALUE 8'h00
`define OCC_BIT_ON 7
`define OCC_BIT_SOFT 6
`define OCC_MARGIN_HI 5
`define OCC_MARGIN_LO 2
`define OCC_MARGIN_OFF0 4'h0
`define OCC_MARGIN_OFF1 4'h1
`define OCC_MARGIN_OFF2 4'h2
`define OCC_MARGIN_LOW_IGN 4'h5
`define OCC_MARGIN_LOW_ACT 4'h6
`define OCC_MARGIN_HIGH_IGN 4'h9
`define OCC_MARGIN_HIGH_ACT 4'hA
`define OCC_LOW_BITS_MASK 8'hFC
`define OCC_CNT_W 24
`endif

// *** occ_pkg.sv ***
package occ_pkg;
  typedef enum logic [1:0] {
    OCC_TARGET_NOMINAL = 2'b00,
    OCC_TARGET_LOWER = 2'b01,
    OCC_TARGET_UPPER = 2'b10
  } occ_target_t;
  typedef enum logic [1:0] {
    OCC_ST_OFF = 2'b00,
    OCC_ST_ON = 2'b01,
    OCC_ST_HOLD = 2'b10,
    OCC_ST_RAMP = 2'b11
  } occ_state_t;
endpackage : occ_pkg
